/* design/pcm_pkg.sv */
// constants, types and register map of the pcm slot audio port
package pcm_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_CHAN = 8'h04;
  localparam logic [7:0] ADR_TX0 = 8'h08;
  localparam logic [7:0] ADR_RX0 = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h20;

  // ----------------------------------------------------------------
  // control word fields and reset values
  // ----------------------------------------------------------------
  localparam int C_EN = 0;
  localparam int C_MASTER = 1;
  localparam int C_LONG = 2;
  localparam int C_LOG = 3;
  localparam int C_WIDE = 6;
  localparam int C_RIGHT = 7;
  localparam int C_LSB = 8;
  localparam int C_FILL = 9;
  localparam int C_PAT = 11;
  localparam int C_REL = 14;
  localparam int C_DIV = 16;
  localparam int H_EN = 12;
  localparam logic [31:0] CTRL_RST = 32'h0003_0000;
  localparam logic [31:0] CTRL_MASK = 32'h00ff_7fff;
  localparam logic [31:0] CHAN_RST = 32'h0000_0000;
  localparam logic [31:0] CHAN_MASK = 32'h0000_7fff;

  // ----------------------------------------------------------------
  // slot and frame geometry
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam logic [3:0] LAST_BIT = 4'hf;
  localparam logic [3:0] LONG_BITS = 4'h3;
  localparam logic [2:0] MAX_LOG = 3'h4;

  typedef enum logic [1:0] {
    FILL_ZERO = 2'b00,
    FILL_ONE = 2'b01,
    FILL_SIGN = 2'b10,
    FILL_PAT = 2'b11
  } fill_e;

  typedef struct packed {
    logic en;
    logic master;
    logic long_sync;
    logic [2:0] slot_log2;
    logic wide;
    logic right_just;
    logic lsb_first;
    fill_e fill;
    logic [2:0] fill_pat;
    logic pin_rel;
    logic [7:0] div;
    logic [2:0] ch_en;
    logic [11:0] ch_slot;
  } cfg_s;

  localparam int CFG_W = $bits(cfg_s);

endpackage

/* design/bit_sync.sv */
// two flip-flop synchroniser for levels and quasi-static words
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // clock of the receiving domain
  input wire logic clk_i,
  // data from the other domain
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o <= meta_q;
  end
endmodule

/* design/slot_format.sv */
// packs a sample into a slot word and unpacks a received slot word
`timescale 1ns/1ps
module slot_format import pcm_pkg::*; (
  // format selection
  input wire logic wide_i,
  input wire logic right_i,
  input wire fill_e fill_i,
  input wire logic [2:0] pat_i,
  // transmit side
  input wire logic [15:0] sample_i,
  output logic [15:0] tx_word_o,
  // receive side
  input wire logic [15:0] rx_word_i,
  output logic [15:0] rx_sample_o
);
  logic [2:0] pad;
  logic [12:0] nb;

  always_comb begin
    unique case (fill_i)
      FILL_ZERO: pad = 3'h0;
      FILL_ONE: pad = 3'h7;
      FILL_SIGN: pad = {3{sample_i[12]}};
      FILL_PAT: pad = pat_i;
    endcase
  end

  always_comb begin
    if (wide_i) begin
      tx_word_o = sample_i;
    end else if (right_i) begin
      tx_word_o = {pad, sample_i[12:0]};
    end else begin
      tx_word_o = {sample_i[12:0], pad};
    end
  end

  // spare bits never reach the sample
  always_comb begin
    nb = right_i ? rx_word_i[12:0] : rx_word_i[15:3];
    rx_sample_o = wide_i ? rx_word_i : {{3{nb[12]}}, nb};
  end
endmodule

/* design/pcm_slot_audio_port.sv */
// time-slotted pcm audio port with wishbone register access
// ----------------------------------------------------------------
// Behaviour
// - master drives bit clock and sync, slave receives
// - port pins released when shared function selected
// - up to three duplex voice channels multiplexed
// - at most sixteen slots per sample interval
// - slot count follows selected bus rate
// - channel sends and receives in same slot
// - data output high impedance in unowned slots
// - data released after falling edge of last bit
// - short or long sync selectable, master or slave
// - short sync one bit wide, rising aligned
// - slave samples sync on falling, starts next rising
// - long sync three bits, starts with slot zero
// - narrowband sample placement and order configurable
// - spare bits ignored on input, filled on output
// - reset format left justified, msb first
// - wideband sixteen bit linear samples
// ----------------------------------------------------------------
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module pcm_slot_audio_port import pcm_pkg::*; (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // link oversampling clock
  input wire logic lclk_i,
  // pcm pins
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe_o,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q, chan_q, rd;
  logic [15:0] tx_q [NCH];
  logic [15:0] hold_q [NCH];
  logic [15:0] rx_q [NCH];
  logic [15:0] tx_fmt [NCH];
  logic [15:0] rx_fmt [NCH];
  logic [15:0] rword_l [NCH];
  logic [15:0] frame_cnt_q;
  cfg_s cfg_q;
  logic ack_q, hit, wr;
  logic req_s, req_seen_q, frame_ev;

  assign hit = cyc_i & stb_i & ~ack_q;
  assign wr = cyc_i & stb_i & we_i & ack_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b+:8] = nw[8*b+:8];
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= hit;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      chan_q <= CHAN_RST;
    end else if (wr && adr_i == ADR_CTRL) begin
      ctrl_q <= merge(ctrl_q, dat_i, sel_i) & CTRL_MASK;
    end else if (wr && adr_i == ADR_CHAN) begin
      chan_q <= merge(chan_q, dat_i, sel_i) & CHAN_MASK;
    end
  end

  // registered so the link sees only clean levels
  always_ff @(posedge clk_i) begin
    cfg_q.en <= ctrl_q[C_EN];
    cfg_q.master <= ctrl_q[C_MASTER];
    cfg_q.long_sync <= ctrl_q[C_LONG];
    cfg_q.slot_log2 <= ctrl_q[C_LOG+:3];
    cfg_q.wide <= ctrl_q[C_WIDE];
    cfg_q.right_just <= ctrl_q[C_RIGHT];
    cfg_q.lsb_first <= ctrl_q[C_LSB];
    cfg_q.fill <= fill_e'(ctrl_q[C_FILL+:2]);
    cfg_q.fill_pat <= ctrl_q[C_PAT+:3];
    cfg_q.pin_rel <= ctrl_q[C_REL];
    cfg_q.div <= ctrl_q[C_DIV+:8];
    cfg_q.ch_en <= chan_q[H_EN+:3];
    cfg_q.ch_slot <= chan_q[11:0];
  end

  always_comb begin
    rd = 32'h0;
    if (adr_i == ADR_CTRL) begin
      rd = ctrl_q;
    end else if (adr_i == ADR_CHAN) begin
      rd = chan_q;
    end else if (adr_i == ADR_STAT) begin
      rd = {16'h0, frame_cnt_q};
    end
    for (int c = 0; c < NCH; c++) begin
      if (adr_i == ADR_TX0 + 8'(4 * c)) begin
        rd = {16'h0, tx_q[c]};
      end
      if (adr_i == ADR_RX0 + 8'(4 * c)) begin
        rd = {16'h0, rx_q[c]};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0;
    end else if (hit && !we_i) begin
      dat_o <= rd;
    end
  end

  assign ack_o = ack_q;

  // ----------------------------------------------------------------
  // frame handshake from the link
  // ----------------------------------------------------------------
  logic req_tgl_q;

  bit_sync #(.W(1)) u_req (
    .clk_i(clk_i),
    .d_i(req_tgl_q),
    .q_o(req_s)
  );

  assign frame_ev = req_s ^ req_seen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_seen_q <= 1'b0;
      frame_cnt_q <= 16'h0;
    end else begin
      req_seen_q <= req_s;
      if (frame_ev) begin
        frame_cnt_q <= frame_cnt_q + 16'h1;
      end
    end
  end

  // link words stay still for at least one slot after the toggle
  for (genvar c = 0; c < NCH; c++) begin : g_sys
    slot_format u_fmt (
      .wide_i(cfg_q.wide),
      .right_i(cfg_q.right_just),
      .fill_i(cfg_q.fill),
      .pat_i(cfg_q.fill_pat),
      .sample_i(tx_q[c]),
      .tx_word_o(tx_fmt[c]),
      .rx_word_i(rword_l[c]),
      .rx_sample_o(rx_fmt[c])
    );

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        tx_q[c] <= 16'h0;
        hold_q[c] <= 16'h0;
        rx_q[c] <= 16'h0;
      end else begin
        if (wr && adr_i == ADR_TX0 + 8'(4 * c)) begin
          tx_q[c] <= 16'(merge({16'h0, tx_q[c]}, dat_i,
                               sel_i));
        end
        if (frame_ev) begin
          hold_q[c] <= tx_fmt[c];
          rx_q[c] <= rx_fmt[c];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  cfg_s cfg_l;
  logic lrst, on_l, rise, fall, m_tick;
  logic [2:0] pin_s;
  logic bclk_s, sync_s, din_s, bclk_d_q;
  logic [7:0] div_q;
  logic bclk_q, sync_q, bclk_oe_q, sync_oe_q, dout_q, dout_oe_q;
  logic [3:0] bit_q, slot_q, nbit, nslot, last_slot, idx_n;
  logic align_q, sync_prev_q, frame_end;
  logic [NCH-1:0] hit_n, hit_q, txb;
  logic [15:0] word_l [NCH];
  logic [15:0] sh_q [NCH];

  bit_sync #(.W(1)) u_lrst (
    .clk_i(lclk_i),
    .d_i(rst_i),
    .q_o(lrst)
  );

  // only safe because the port is stopped while reconfigured
  bit_sync #(.W(CFG_W)) u_cfg (
    .clk_i(lclk_i),
    .d_i(cfg_q),
    .q_o(cfg_l)
  );

  bit_sync #(.W(3)) u_pin (
    .clk_i(lclk_i),
    .d_i({din_i, sync_i, bclk_i}),
    .q_o(pin_s)
  );

  assign bclk_s = pin_s[0];
  assign sync_s = pin_s[1];
  assign din_s = pin_s[2];
  assign on_l = cfg_l.en & ~cfg_l.pin_rel;

  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l || !cfg_l.master) begin
      div_q <= 8'h0;
      bclk_q <= 1'b0;
    end else if (div_q == cfg_l.div) begin
      div_q <= 8'h0;
      bclk_q <= ~bclk_q;
    end else begin
      div_q <= div_q + 8'h1;
    end
  end

  always_ff @(posedge lclk_i) begin
    bclk_d_q <= bclk_s;
  end

  assign m_tick = cfg_l.master & (div_q == cfg_l.div);
  assign rise = on_l & (cfg_l.master ? (m_tick & ~bclk_q)
                                     : (bclk_s & ~bclk_d_q));
  assign fall = on_l & (cfg_l.master ? (m_tick & bclk_q)
                                     : (~bclk_s & bclk_d_q));

  // slot position
  assign last_slot = (cfg_l.slot_log2 >= MAX_LOG) ? 4'hf :
      4'((5'h1 << cfg_l.slot_log2) - 5'h1);
  assign frame_end = (bit_q == LAST_BIT) & (slot_q >= last_slot);

  always_comb begin
    if (align_q) begin
      nbit = 4'h0;
      nslot = 4'h0;
    end else if (bit_q == LAST_BIT) begin
      nbit = 4'h0;
      nslot = (slot_q >= last_slot) ? 4'h0 : slot_q + 4'h1;
    end else begin
      nbit = bit_q + 4'h1;
      nslot = slot_q;
    end
  end

  assign idx_n = cfg_l.lsb_first ? nbit : LAST_BIT - nbit;

  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l) begin
      bit_q <= LAST_BIT;
      slot_q <= last_slot;
    end else if (rise) begin
      bit_q <= nbit;
      slot_q <= nslot;
    end else if (fall && !cfg_l.master && cfg_l.long_sync &&
                 sync_s && !sync_prev_q) begin
      bit_q <= 4'h0;
      slot_q <= 4'h0;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l || cfg_l.master || cfg_l.long_sync) begin
      align_q <= 1'b0;
    end else if (fall && sync_s) begin
      align_q <= 1'b1;
    end else if (rise) begin
      align_q <= 1'b0;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l) begin
      sync_prev_q <= 1'b0;
    end else if (fall) begin
      sync_prev_q <= sync_s;
    end
  end

  // master sync and pin drive
  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l || !cfg_l.master) begin
      sync_q <= 1'b0;
    end else if (rise && cfg_l.long_sync) begin
      sync_q <= (nslot == 4'h0) && (nbit < LONG_BITS);
    end else if (rise) begin
      sync_q <= (nbit == LAST_BIT) && (nslot == last_slot);
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst) begin
      bclk_oe_q <= 1'b0;
      sync_oe_q <= 1'b0;
    end else begin
      bclk_oe_q <= on_l & cfg_l.master;
      sync_oe_q <= on_l & cfg_l.master;
    end
  end

  // channel slot ownership, shared by both directions
  for (genvar c = 0; c < NCH; c++) begin : g_link
    assign hit_n[c] = cfg_l.ch_en[c] &
        (cfg_l.ch_slot[4*c+:4] == nslot);
    assign txb[c] = word_l[c][idx_n];

    always_ff @(posedge lclk_i) begin
      if (lrst) begin
        word_l[c] <= 16'h0;
      end else if (fall && frame_end) begin
        word_l[c] <= hold_q[c];
      end
    end

    always_ff @(posedge lclk_i) begin
      if (lrst) begin
        sh_q[c] <= 16'h0;
        rword_l[c] <= 16'h0;
      end else if (fall && hit_q[c]) begin
        sh_q[c] <= cfg_l.lsb_first ? {din_s, sh_q[c][15:1]}
                                   : {sh_q[c][14:0], din_s};
        if (bit_q == LAST_BIT) begin
          rword_l[c] <= cfg_l.lsb_first ? {din_s, sh_q[c][15:1]}
                                        : {sh_q[c][14:0], din_s};
        end
      end
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst || !on_l) begin
      hit_q <= '0;
      dout_q <= 1'b0;
      dout_oe_q <= 1'b0;
    end else if (rise) begin
      hit_q <= hit_n;
      dout_q <= |(hit_n & txb);
      dout_oe_q <= |hit_n;
    end else if (fall && bit_q == LAST_BIT) begin
      dout_oe_q <= 1'b0;
    end
  end

  always_ff @(posedge lclk_i) begin
    if (lrst) begin
      req_tgl_q <= 1'b0;
    end else if (fall && frame_end) begin
      req_tgl_q <= ~req_tgl_q;
    end
  end

  assign bclk_o = bclk_q;
  assign bclk_oe_o = bclk_oe_q;
  assign sync_o = sync_q;
  assign sync_oe_o = sync_oe_q;
  assign dout_o = dout_q;
  assign dout_oe_o = dout_oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_oe_owned_slot: assert property (@(posedge lclk_i) disable iff (lrst)
    dout_oe_q |-> |hit_q) else $error("data driven in unowned slot");
  a_oe_last_bit: assert property (@(posedge lclk_i) disable iff (lrst)
    fall && bit_q == LAST_BIT |=> !dout_oe_q)
    else $error("data not released after last bit");
  a_short_sync_pos: assert property (@(posedge lclk_i) disable iff (lrst)
    cfg_l.master && !cfg_l.long_sync && $rose(sync_q) |->
    bit_q == LAST_BIT && slot_q == last_slot)
    else $error("short sync not in bit before slot zero");
  a_long_sync_start: assert property (@(posedge lclk_i)
    disable iff (lrst)
    cfg_l.master && cfg_l.long_sync && $rose(sync_q) |->
    bit_q == 4'h0 && slot_q == 4'h0)
    else $error("long sync not with first bit");
  a_long_sync_len: assert property (@(posedge lclk_i) disable iff (lrst)
    cfg_l.master && cfg_l.long_sync && $fell(sync_q) && on_l |->
    bit_q == LONG_BITS) else $error("long sync not three bits");
  a_master_pins: assert property (@(posedge lclk_i) disable iff (lrst)
    on_l && cfg_l.master ##1 on_l && cfg_l.master |->
    bclk_oe_q && sync_oe_q) else $error("master pins not driven");
  a_pin_release: assert property (@(posedge lclk_i) disable iff (lrst)
    cfg_l.pin_rel |=> !bclk_oe_q && !sync_oe_q && !dout_oe_q)
    else $error("pins held while released");
  a_slot_limit: assert property (@(posedge lclk_i) disable iff (lrst)
    on_l |-> slot_q <= last_slot) else $error("slot past limit");
  a_slave_start: assert property (@(posedge lclk_i) disable iff (lrst)
    align_q && rise |=> bit_q == 4'h0 && slot_q == 4'h0)
    else $error("slave did not start slot zero");
  a_launch_rise: assert property (@(posedge lclk_i) disable iff (lrst)
    $rose(dout_oe_q) |-> $past(rise))
    else $error("data launched off rising edge");
  a_reset_format: assert property (@(posedge clk_i)
    $past(rst_i) |-> !ctrl_q[C_RIGHT] && !ctrl_q[C_LSB] &&
    !ctrl_q[C_WIDE]) else $error("reset format wrong");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q) else $error("ack longer than one cycle");

  c_short_master: cover property (@(posedge lclk_i) disable iff (lrst)
    cfg_l.master && !cfg_l.long_sync && $rose(sync_q));
  c_long_slave: cover property (@(posedge lclk_i) disable iff (lrst)
    !cfg_l.master && cfg_l.long_sync && fall && sync_s && !sync_prev_q);
  c_rx_word: cover property (@(posedge clk_i) disable iff (rst_i)
    frame_ev && cfg_q.ch_en != 3'h0);
  c_wb_write: cover property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == ADR_CTRL);

endmodule

/* sim/pcm_codec_model.sv */
// codec or bus master model facing the port's serial pins
`timescale 1ns/1ps
module pcm_codec_model (
  // role and frame shape
  input wire logic gen_i,
  input wire logic long_i,
  input wire logic [2:0] log2_i,
  // board wires
  input wire logic bclk_w_i,
  input wire logic sync_w_i,
  input wire logic dout_i,
  input wire logic dout_oe_i,
  // driven by this side
  output logic bclk_o,
  output logic sync_o,
  output logic din_o
);
  int nbits;
  int gpos = 0;
  int pos = 1000;
  int cnt = 0;
  int frames = 0;
  logic sync_prev = 1'b0;
  logic [15:0] sh;
  logic [15:0] cap [16];
  logic [7:0] oe_n [16];
  logic oe_late;

  assign nbits = 16 << ((log2_i > 3'h4) ? 3'h4 : log2_i);
  // level just before the edge, the port may release on that edge
  assign #1 oe_late = dout_oe_i;
  initial begin
    bclk_o = 1'b0;
    sync_o = 1'b0;
    din_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // master role: clock stands still low unless this side leads
  // ----------------------------------------------------------------
  always #48 begin
    if (gen_i) bclk_o = ~bclk_o;
    else bclk_o = 1'b0;
  end
  always @(posedge bclk_o) begin
    gpos = (gpos + 1) % nbits;
    if (long_i) sync_o = (gpos < 3);
    else sync_o = (gpos == nbits - 1);
  end

  // ----------------------------------------------------------------
  // data: sample on falls, launch on rises
  // ----------------------------------------------------------------
  always @(negedge bclk_w_i) begin
    if (long_i && sync_w_i && !sync_prev) begin
      pos = 0;
      frames++;
    end
    if (pos >= 0 && pos < 256) begin
      if (pos % 16 == 0) cnt = 0;
      // a released line reads back inverted, never stale
      sh[15 - pos % 16] = (oe_late === 1'b1) ? dout_i : ~dout_i;
      if (oe_late === 1'b1) cnt++;
      if (pos % 16 == 15) begin
        cap[pos / 16] = sh;
        oe_n[pos / 16] = 8'(cnt);
      end
    end
    if (!long_i && sync_w_i) begin
      pos = -1;
      frames++;
    end
    sync_prev = sync_w_i;
  end
  always @(posedge bclk_w_i) begin
    logic [15:0] w;
    pos++;
    w = {~4'(pos / 16), 12'h5a3};
    // outside a frame the line wanders, never a stale level
    if (pos >= 0 && pos < 256) din_o = w[15 - pos % 16];
    else din_o = ~din_o;
  end
endmodule

/* sim/pcm_slot_audio_port_bench.sv */
// self-checking bench for the pcm slot audio port
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pcm_slot_audio_port_bench import pcm_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic lclk = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, bclk, bclk_oe, sync, sync_oe, dout, dout_oe;
  logic bclk_m, sync_m, din;
  logic gen = 1'b0;
  logic lng = 1'b0;
  logic [2:0] lg2 = 3'h0;
  logic [31:0] q;
  logic [31:0] cfgs [8];
  logic [31:0] chans [8];
  logic [15:0] txs [3] = '{16'h1abc, 16'h0123, 16'h1f00};
  int error_cnt = 0;
  int n_compared = 0;
  wire bclk_w = bclk_oe ? bclk : bclk_m;
  wire sync_w = sync_oe ? sync : sync_m;

  always #5 clk_i = ~clk_i;
  initial begin
    #1.7;
    forever #6 lclk = ~lclk;
  end

  pcm_slot_audio_port dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .lclk_i(lclk), .bclk_i(bclk_w),
    .bclk_o(bclk), .bclk_oe_o(bclk_oe), .sync_i(sync_w), .sync_o(sync),
    .sync_oe_o(sync_oe), .din_i(din), .dout_o(dout),
    .dout_oe_o(dout_oe));
  pcm_codec_model u_codec (.gen_i(gen), .long_i(lng), .log2_i(lg2),
    .bclk_w_i(bclk_w), .sync_w_i(sync_w), .dout_i(dout),
    .dout_oe_i(dout_oe), .bclk_o(bclk_m), .sync_o(sync_m), .din_o(din));

  // ----------------------------------------------------------------
  // bus access, expectations, verdict
  // ----------------------------------------------------------------
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      results();
    end
  endtask

  function automatic logic [31:0] mk(input logic m, l, input logic [2:0] g,
      input logic wd, rj, ls, input logic [1:0] fl, input logic [2:0] pt);
    return CTRL_RST | (32'(m) << C_MASTER) | (32'(l) << C_LONG)
      | (32'(g) << C_LOG) | (32'(wd) << C_WIDE) | (32'(rj) << C_RIGHT)
      | (32'(ls) << C_LSB) | (32'(fl) << C_FILL) | (32'(pt) << C_PAT);
  endfunction

  function automatic logic [15:0] rev16(input logic [15:0] w);
    for (int i = 0; i < 16; i++)
      rev16[i] = w[15 - i];
  endfunction

  function automatic logic [15:0] exp_tx(input logic [15:0] s,
      input logic [31:0] c);
    logic [2:0] f;
    logic [15:0] w;
    case (fill_e'(c[C_FILL +: 2]))
      FILL_ZERO: f = 3'h0;
      FILL_ONE: f = 3'h7;
      FILL_SIGN: f = {3{s[12]}};
      default: f = c[C_PAT +: 3];
    endcase
    if (c[C_WIDE]) w = s;
    else if (c[C_RIGHT]) w = {f, s[12:0]};
    else w = {s[12:0], f};
    return c[C_LSB] ? rev16(w) : w;
  endfunction

  function automatic logic [15:0] exp_rx(input logic [15:0] d,
      input logic [31:0] c);
    logic [15:0] w;
    w = c[C_LSB] ? rev16(d) : d;
    if (c[C_WIDE]) return w;
    if (c[C_RIGHT]) return {{3{w[12]}}, w[12:0]};
    return {{3{w[15]}}, w[15:3]};
  endfunction

  // stop, reshape, restart, then judge a settled frame
  task automatic run_cfg(input logic [31:0] c, input logic [31:0] ch);
    int f0;
    int n;
    logic [3:0] sl;
    logic [15:0] own;
    logic [15:0] fs;
    wb(1'b1, ADR_CTRL, 32'h0, 4'hf, q);
    gen <= ~c[C_MASTER];
    lng <= c[C_LONG];
    lg2 <= c[C_LOG +: 3];
    wb(1'b1, ADR_CHAN, ch, 4'hf, q);
    for (int k = 0; k < NCH; k++)
      wb(1'b1, ADR_TX0 + 8'(4 * k), {16'h0, txs[k]}, 4'hf, q);
    wb(1'b1, ADR_CTRL, c | 32'h1, 4'hf, q);
    wb(1'b0, ADR_STAT, 32'h0, 4'hf, q);
    fs = q[15:0];
    f0 = u_codec.frames;
    n = 0;
    while (u_codec.frames < f0 + 5 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40000) begin
      error_cnt++;
      results();
    end
    wb(1'b0, ADR_STAT, 32'h0, 4'hf, q);
    `CHK("frame count", 1'b1, (q[15:0] - fs) >= 16'h4)
    `CHK("bclk_oe", c[C_MASTER], bclk_oe)
    `CHK("sync_oe", c[C_MASTER], sync_oe)
    own = 16'h0;
    for (int k = 0; k < NCH; k++) begin
      if (ch[12 + k]) begin
        sl = ch[4 * k +: 4];
        own[sl] = 1'b1;
        `CHK("tx word", exp_tx(txs[k], c), u_codec.cap[sl])
        wb(1'b0, ADR_RX0 + 8'(4 * k), 32'h0, 4'hf, q);
        `CHK("rx sample", exp_rx({~sl, 12'h5a3}, c), q[15:0])
      end
    end
    for (int s = 0; s < (16 << (c[C_LOG +: 3] > 3'h4 ? 3'h4
        : c[C_LOG +: 3])) / 16; s++)
      `CHK("oe bits", own[s] ? 8'h10 : 8'h00, u_codec.oe_n[s])
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    // tx words are written before each enable, so two-frame latency is met
    cfgs = '{mk(1, 0, 2, 0, 0, 0, 0, 0), mk(1, 0, 2, 0, 0, 0, 1, 0),
      mk(1, 1, 2, 0, 0, 0, 2, 0), mk(1, 0, 2, 0, 0, 0, 3, 5),
      mk(0, 0, 2, 0, 1, 0, 2, 0), mk(0, 1, 2, 1, 0, 0, 0, 0),
      mk(1, 0, 4, 0, 0, 1, 0, 0), mk(0, 0, 0, 0, 0, 0, 0, 0)};
    chans = '{32'h7231, 32'h7231, 32'h7231, 32'h7231, 32'h7231,
      32'h7231, 32'h7f31, 32'h1000};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADR_CTRL, 32'h0, 4'hf, q);
    `CHK("ctrl reset", CTRL_RST, q)
    wb(1'b0, ADR_CHAN, 32'h0, 4'hf, q);
    `CHK("chan reset", CHAN_RST, q)
    `CHK("dout_oe idle", 1'b0, dout_oe)
    wb(1'b1, 8'h3c, 32'hffff_ffff, 4'hf, q);
    wb(1'b0, 8'h3c, 32'h0, 4'hf, q);
    `CHK("unmapped", 32'h0, q)
    wb(1'b1, ADR_CHAN, 32'hffff_ffff, 4'h1, q);
    wb(1'b0, ADR_CHAN, 32'h0, 4'hf, q);
    `CHK("byte lane", 32'h0000_00ff, q)
    for (int i = 0; i < 8; i++)
      run_cfg(cfgs[i], chans[i]);
    wb(1'b1, ADR_CTRL, 32'h0, 4'hf, q);
    gen <= 1'b0;
    wb(1'b1, ADR_CTRL, cfgs[0] | 32'h1 | (32'h1 << C_REL), 4'hf, q);
    repeat (200) @(posedge clk_i);
    `CHK("rel bclk_oe", 1'b0, bclk_oe)
    `CHK("rel dout_oe", 1'b0, dout_oe)
    results();
  end
endmodule
